/* File: motion_alarm_pkg.sv */
// Function
// - move request before homing completes, with homing not running, raises alarm 082, all modes
// - move request while homing is running raises alarm 084, all modes
// - move to a missing position number raises 085, never in point-stop modes
// - software reset request while servo is on raises alarm 090
// - teaching with position number above 63 raises 091, not in point-stop
// - write strobe during jog in pattern-1 teaching, positioner 2, raises 092
// - write strobe before homing in pattern-1 teaching, positioner 2, raises 093
package motion_alarm_pkg;

	// register byte offsets
	localparam logic [7:0] OFS_CTRL = 8'h00;
	localparam logic [7:0] OFS_STAT = 8'h04;
	localparam logic [7:0] OFS_ICLR = 8'h08;
	localparam logic [7:0] OFS_IEN = 8'h0C;
	localparam logic [7:0] OFS_ALARM = 8'h10;
	localparam logic [7:0] OFS_POSLO = 8'h14;
	localparam logic [7:0] OFS_POSHI = 8'h18;
	localparam logic [7:0] OFS_PINS = 8'h1C;

	// field positions
	localparam int unsigned CTRL_PAT1_BIT = 4;
	localparam int unsigned ALARM_ACT_BIT = 16;

	// reset values
	localparam logic [2:0] MODE_RST = 3'h0;
	localparam logic [6:0] IEN_RST = 7'h00;
	localparam logic [63:0] POS_VALID_RST = 64'h0000_0000_0000_0000;

	// alarm codes and event indices
	localparam int unsigned NUM_EV = 7;
	localparam int unsigned EV_HOME_INC = 0;
	localparam int unsigned EV_HOMING = 1;
	localparam int unsigned EV_POS_NUM = 2;
	localparam int unsigned EV_SRST_SV = 3;
	localparam int unsigned EV_TEACH_NUM = 4;
	localparam int unsigned EV_JOG_WRT = 5;
	localparam int unsigned EV_WRT_HOME = 6;
	localparam logic [11:0] ALM_NONE = 12'h000;
	localparam logic [11:0] ALM_HOME_INC = 12'h082;
	localparam logic [11:0] ALM_HOMING = 12'h084;
	localparam logic [11:0] ALM_POS_NUM = 12'h085;
	localparam logic [11:0] ALM_SRST_SV = 12'h090;
	localparam logic [11:0] ALM_TEACH_NUM = 12'h091;
	localparam logic [11:0] ALM_JOG_WRT = 12'h092;
	localparam logic [11:0] ALM_WRT_HOME = 12'h093;

	// highest teachable position number
	localparam logic [7:0] POS_MAX = 8'h3F;

	localparam logic [1:0] RESP_OKAY = 2'b00;
	localparam logic [1:0] RESP_SLVERR = 2'b10;

	typedef enum logic [2:0]
	{
		MODE_POS1 = 3'b000,
		MODE_PULSE = 3'b001,
		MODE_POS2 = 3'b010,
		MODE_SPS1 = 3'b011,
		MODE_SPS2 = 3'b100
	} mode_t;

	// point-stop modes, and any unused code, skip position checks
	function automatic logic is_point_stop(input logic [2:0] mode);
		return mode >= MODE_SPS1;
	endfunction

	// lowest event index wins the latched code
	function automatic logic [11:0] code_of(input logic [6:0] ev);
		logic [11:0] c;
		c = ALM_NONE;
		if (ev[EV_WRT_HOME]) c = ALM_WRT_HOME;
		if (ev[EV_JOG_WRT]) c = ALM_JOG_WRT;
		if (ev[EV_TEACH_NUM]) c = ALM_TEACH_NUM;
		if (ev[EV_SRST_SV]) c = ALM_SRST_SV;
		if (ev[EV_POS_NUM]) c = ALM_POS_NUM;
		if (ev[EV_HOMING]) c = ALM_HOMING;
		if (ev[EV_HOME_INC]) c = ALM_HOME_INC;
		return c;
	endfunction

	// merge write data into a word under byte strobes
	function automatic logic [31:0] apply_strb(input logic [31:0] old,
		input logic [31:0] wd, input logic [3:0] strb);
		logic [31:0] v;
		v = old;
		for (int i = 0; i < 4; i++)
		begin
			if (strb[i]) v[i*8 +: 8] = wd[i*8 +: 8];
		end
		return v;
	endfunction

endpackage

/* File: input_sync.sv */
`timescale 1ns/1ps
module input_sync
	import motion_alarm_pkg::*;
#(
	parameter int W = 1
)
(
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [W-1:0] din,
	output logic [W-1:0] level,
	output logic [W-1:0] rise
);

	typedef struct packed
	{
		logic [W-1:0] s1;
		logic [W-1:0] s2;
		logic [W-1:0] lvl;
		logic [W-1:0] rise;
	} sync_t;

	sync_t sync_r;
	sync_t sync_nxt;

	// two-flop synchroniser, then level and rising-edge registers
	always_comb
	begin
		sync_nxt.s1 = din;
		sync_nxt.s2 = sync_r.s1;
		sync_nxt.lvl = sync_r.s2;
		sync_nxt.rise = sync_r.s2 & ~sync_r.lvl;
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			sync_r <= '0;
		else
			sync_r <= sync_nxt;
	end

	assign level = sync_r.lvl;
	assign rise = sync_r.rise;

endmodule

/* File: alarm_latch.sv */
`timescale 1ns/1ps
module alarm_latch
	import motion_alarm_pkg::*;
(
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [6:0] events,
	input wire logic alarm_reset,
	output logic [11:0] alarm_code,
	output logic alarm_active
);

	typedef struct packed
	{
		logic active;
		logic [11:0] code;
	} latch_t;

	latch_t latch_r;
	latch_t latch_nxt;

	// first alarm is held; a new event beats a reset in the same cycle
	always_comb
	begin
		latch_nxt = latch_r;
		if (alarm_reset)
		begin
			latch_nxt.active = 1'b0;
			latch_nxt.code = ALM_NONE;
		end
		if ((|events) && (!latch_r.active || alarm_reset))
		begin
			latch_nxt.active = 1'b1;
			latch_nxt.code = code_of(events);
		end
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			latch_r <= '0;
		else
			latch_r <= latch_nxt;
	end

	assign alarm_code = latch_r.code;
	assign alarm_active = latch_r.active;

	code_hold_a: assert property (@(posedge aclk) disable iff (!aresetn)
		alarm_active && !alarm_reset |=> $stable(alarm_code) && alarm_active)
		else $error("latched alarm code changed without reset");

endmodule

/* File: motion_command_alarm_checker.sv */
`timescale 1ns/1ps
module motion_command_alarm_checker
	import motion_alarm_pkg::*;
(
	input wire logic aclk,
	input wire logic aresetn,
	// axi4-lite register port
	input wire logic [7:0] awaddr,
	input wire logic awvalid,
	output logic awready,
	input wire logic [31:0] wdata,
	input wire logic [3:0] wstrb,
	input wire logic wvalid,
	output logic wready,
	output logic [1:0] bresp,
	output logic bvalid,
	input wire logic bready,
	input wire logic [7:0] araddr,
	input wire logic arvalid,
	output logic arready,
	output logic [31:0] rdata,
	output logic [1:0] rresp,
	output logic rvalid,
	input wire logic rready,
	// parallel command inputs from the host pins
	input wire logic move_request,
	input wire logic [7:0] position_number,
	input wire logic soft_reset_request,
	input wire logic position_write_strobe,
	input wire logic jog_fwd_input,
	input wire logic jog_rev_input,
	input wire logic teach_mode_input,
	// state flags from the motion logic on this clock
	input wire logic home_done_flag,
	input wire logic homing_busy,
	input wire logic servo_on_flag,
	input wire logic motion_active_flag,
	// alarm outputs
	output logic [11:0] alarm_code,
	output logic alarm_active,
	output logic irq
);

	typedef struct packed
	{
		logic aw_full;
		logic [7:0] aw_addr;
		logic w_full;
		logic [31:0] w_data;
		logic [3:0] w_strb;
		logic awready;
		logic wready;
		logic bvalid;
		logic [1:0] bresp;
		logic arready;
		logic rvalid;
		logic [1:0] rresp;
		logic [31:0] rdata;
		logic [2:0] mode;
		logic pat1;
		logic [6:0] irq_en;
		logic [6:0] irq_stat;
		logic [63:0] pos_valid;
		logic irq;
		logic alarm_rst;
	} state_t;

	state_t state_r;
	state_t state_nxt;

	logic [5:0] pin_lvl;
	logic [5:0] pin_rise;
	logic [7:0] pos_q;
	logic [6:0] ev;
	logic [11:0] latch_code;
	logic latch_active;
	logic move_rise;
	logic srst_rise;
	logic position_write_strobe_rise;
	logic jog_on;
	logic teaching;
	logic pat1_teach;
	logic pos_exists;

	// command pins pass three flops before any decode
	input_sync #(.W(6)) u_cmd_sync
	(
		.aclk(aclk),
		.aresetn(aresetn),
		.din({move_request, soft_reset_request, position_write_strobe,
			jog_fwd_input, jog_rev_input, teach_mode_input}),
		.level(pin_lvl),
		.rise(pin_rise)
	);

	// position number is held steady by the host around a request
	input_sync #(.W(8)) u_pos_sync
	(
		.aclk(aclk),
		.aresetn(aresetn),
		.din(position_number),
		.level(pos_q),
		.rise()
	);

	alarm_latch u_latch
	(
		.aclk(aclk),
		.aresetn(aresetn),
		.events(ev),
		.alarm_reset(state_r.alarm_rst),
		.alarm_code(latch_code),
		.alarm_active(latch_active)
	);

	// decoded request edges and conditions
	assign move_rise = pin_rise[5];
	assign srst_rise = pin_rise[4];
	assign position_write_strobe_rise = pin_rise[3];
	assign jog_on = pin_lvl[2] | pin_lvl[1] | motion_active_flag;
	assign teaching = pin_lvl[0];
	assign pat1_teach = teaching && state_r.pat1 && (state_r.mode == MODE_POS2);
	assign pos_exists = (pos_q <= POS_MAX) && state_r.pos_valid[pos_q[5:0]];

	// alarm events, one per code
	always_comb
	begin
		ev = '0;
		ev[EV_HOME_INC] = move_rise && !home_done_flag && !homing_busy;
		ev[EV_HOMING] = move_rise && homing_busy;
		ev[EV_POS_NUM] = move_rise && home_done_flag && !homing_busy &&
			!is_point_stop(state_r.mode) && !pos_exists;
		ev[EV_SRST_SV] = srst_rise && servo_on_flag;
		ev[EV_TEACH_NUM] = position_write_strobe_rise && teaching &&
			!is_point_stop(state_r.mode) && (pos_q > POS_MAX);
		ev[EV_JOG_WRT] = position_write_strobe_rise && pat1_teach && jog_on;
		ev[EV_WRT_HOME] = position_write_strobe_rise && pat1_teach && !home_done_flag;
	end

	// bus slave, registers and sticky status
	always_comb
	begin
		logic [31:0] tmp;
		logic [6:0] clr;
		logic wr_go;
		tmp = '0;
		clr = '0;
		wr_go = 1'b0;
		state_nxt = state_r;
		state_nxt.alarm_rst = 1'b0;
		// address and data are captured in either order
		if (awvalid && state_r.awready)
		begin
			state_nxt.aw_full = 1'b1;
			state_nxt.aw_addr = awaddr;
		end
		if (wvalid && state_r.wready)
		begin
			state_nxt.w_full = 1'b1;
			state_nxt.w_data = wdata;
			state_nxt.w_strb = wstrb;
		end
		if (state_r.bvalid && bready)
			state_nxt.bvalid = 1'b0;
		wr_go = state_r.aw_full && state_r.w_full && !state_r.bvalid;
		// register write once both halves are held
		if (wr_go)
		begin
			state_nxt.aw_full = 1'b0;
			state_nxt.w_full = 1'b0;
			state_nxt.bvalid = 1'b1;
			state_nxt.bresp = RESP_OKAY;
			unique case (state_r.aw_addr)
				OFS_CTRL:
				begin
					tmp = apply_strb({27'h000_0000, state_r.pat1, 1'b0,
						state_r.mode}, state_r.w_data, state_r.w_strb);
					state_nxt.mode = tmp[2:0];
					state_nxt.pat1 = tmp[CTRL_PAT1_BIT];
				end
				OFS_ICLR:
				begin
					if (state_r.w_strb[0]) clr = state_r.w_data[6:0];
				end
				OFS_IEN:
				begin
					tmp = apply_strb({25'h000_0000, state_r.irq_en},
						state_r.w_data, state_r.w_strb);
					state_nxt.irq_en = tmp[6:0];
				end
				OFS_ALARM:
				begin
					state_nxt.alarm_rst = 1'b1;
				end
				OFS_POSLO:
				begin
					state_nxt.pos_valid[31:0] = apply_strb(
						state_r.pos_valid[31:0], state_r.w_data,
						state_r.w_strb);
				end
				OFS_POSHI:
				begin
					state_nxt.pos_valid[63:32] = apply_strb(
						state_r.pos_valid[63:32], state_r.w_data,
						state_r.w_strb);
				end
				OFS_STAT, OFS_PINS:
				begin
					// read-only, write ignored
				end
				default:
				begin
					state_nxt.bresp = RESP_SLVERR;
				end
			endcase
		end
		state_nxt.awready = !state_nxt.aw_full && !state_nxt.bvalid;
		state_nxt.wready = !state_nxt.w_full && !state_nxt.bvalid;
		// read answers one cycle after the address is taken
		if (state_r.rvalid && rready)
			state_nxt.rvalid = 1'b0;
		if (arvalid && state_r.arready)
		begin
			state_nxt.rvalid = 1'b1;
			state_nxt.rresp = RESP_OKAY;
			unique case (araddr)
				OFS_CTRL: state_nxt.rdata = {27'h000_0000, state_r.pat1,
					1'b0, state_r.mode};
				OFS_STAT: state_nxt.rdata = {25'h000_0000, state_r.irq_stat};
				OFS_ICLR: state_nxt.rdata = 32'h0000_0000;
				OFS_IEN: state_nxt.rdata = {25'h000_0000, state_r.irq_en};
				OFS_ALARM: state_nxt.rdata = {15'h0000, latch_active, 4'h0,
					latch_code};
				OFS_POSLO: state_nxt.rdata = state_r.pos_valid[31:0];
				OFS_POSHI: state_nxt.rdata = state_r.pos_valid[63:32];
				OFS_PINS: state_nxt.rdata = {16'h0000, pos_q, 2'b00, pin_lvl};
				default:
				begin
					state_nxt.rdata = 32'h0000_0000;
					state_nxt.rresp = RESP_SLVERR;
				end
			endcase
		end
		state_nxt.arready = !state_nxt.rvalid;
		// sticky status: a new event beats a clear in the same cycle
		state_nxt.irq_stat = (state_r.irq_stat & ~clr) | ev;
		state_nxt.irq = |(state_nxt.irq_stat & state_nxt.irq_en);
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			state_r <= '0;
			state_r.mode <= MODE_RST;
			state_r.irq_en <= IEN_RST;
			state_r.pos_valid <= POS_VALID_RST;
		end
		else
			state_r <= state_nxt;
	end

	// outputs straight from flops
	assign awready = state_r.awready;
	assign wready = state_r.wready;
	assign bvalid = state_r.bvalid;
	assign bresp = state_r.bresp;
	assign arready = state_r.arready;
	assign rvalid = state_r.rvalid;
	assign rresp = state_r.rresp;
	assign rdata = state_r.rdata;
	assign irq = state_r.irq;
	assign alarm_code = latch_code;
	assign alarm_active = latch_active;

	default clocking cb @(posedge aclk);
	endclocking
	default disable iff (!aresetn);

	// alarm 082 sets status and the latch on the next edge
	home_incomplete_a: assert property (
		move_rise && !home_done_flag && !homing_busy
		|=> state_r.irq_stat[EV_HOME_INC] && alarm_active)
		else $error("move before home done did not raise 082");

	// status may be cleared by software right after, so look one edge only
	homing_running_a: assert property (
		move_rise && homing_busy |=>
		state_r.irq_stat[EV_HOMING] && alarm_active)
		else $error("move during homing did not raise 084");

	pos_num_mode_a: assert property (
		$rose(state_r.irq_stat[EV_POS_NUM]) |->
		!is_point_stop($past(state_r.mode)) && $past(move_rise))
		else $error("085 raised in point-stop mode or without a move");

	srst_servo_a: assert property (
		srst_rise && servo_on_flag |=> state_r.irq_stat[EV_SRST_SV])
		else $error("reset with servo on did not raise 090");

	teach_num_a: assert property (
		position_write_strobe_rise && teaching && !is_point_stop(state_r.mode) &&
		pos_q > POS_MAX |=> state_r.irq_stat[EV_TEACH_NUM])
		else $error("position above 63 in teaching did not raise 091");

	jog_write_a: assert property (
		$rose(state_r.irq_stat[EV_JOG_WRT]) |->
		$past(state_r.mode) == MODE_POS2 && $past(state_r.pat1) &&
		$past(jog_on))
		else $error("092 raised outside pattern-1 teaching or no jog");

	write_home_a: assert property (
		position_write_strobe_rise && pat1_teach && !home_done_flag
		|=> state_r.irq_stat[EV_WRT_HOME])
		else $error("write before home done did not raise 093");

	irq_level_a: assert property (
		(|(state_r.irq_stat & state_r.irq_en)) |-> irq)
		else $error("enabled status bit set but no interrupt");

	// point-stop modes never raise the position-number alarms
	point_stop_quiet_a: assert property (
		is_point_stop(state_r.mode) |=>
		!$rose(state_r.irq_stat[EV_POS_NUM]) &&
		!$rose(state_r.irq_stat[EV_TEACH_NUM]))
		else $error("position alarm raised in point-stop mode");

	// the registered reset pulse empties the latch one edge later
	alarm_reset_a: assert property (
		state_r.alarm_rst && !(|ev) |=>
		!alarm_active && alarm_code == ALM_NONE)
		else $error("alarm register write did not reset the latch");

	// an event keeps its status bit even against a clear in that cycle
	set_beats_clear_a: assert property (
		(|ev) |=> (state_r.irq_stat & $past(ev)) == $past(ev))
		else $error("event lost its sticky status bit");

	alarm_read_a: assert property (
		arvalid && arready && araddr == OFS_ALARM |=>
		rvalid && rdata[11:0] == $past(alarm_code) &&
		rdata[ALARM_ACT_BIT] == $past(alarm_active))
		else $error("alarm register read does not show latched code");

	move_alarm_c: cover property (move_rise && !home_done_flag ##1 irq);
	jog_write_c: cover property (ev[EV_JOG_WRT] ##[1:20] state_r.alarm_rst);
	reset_race_c: cover property (state_r.alarm_rst && (|ev));
	read_write_c: cover property (bvalid && rvalid);
	alarm_clear_c: cover property (state_r.alarm_rst ##1 !alarm_active);

endmodule

/* File: host_pin_model.sv */
`timescale 1ns/1ps
// host side: drives command pins and the motion state flags
module host_pin_model
(
	input wire logic aclk,
	output logic move_request,
	output logic [7:0] position_number,
	output logic soft_reset_request,
	output logic position_write_strobe,
	output logic jog_fwd_input,
	output logic jog_rev_input,
	output logic teach_mode_input,
	output logic home_done_flag,
	output logic homing_busy,
	output logic servo_on_flag,
	output logic motion_active_flag
);
	logic [2:0] strobes;

	// strobe pins in order move, soft reset, position write
	assign {move_request, soft_reset_request, position_write_strobe} = strobes;

	// all pins idle at time zero
	initial
	begin
		strobes = 3'h0;
		position_number = 8'h00;
		{teach_mode_input, jog_fwd_input, jog_rev_input} = 3'h0;
		{home_done_flag, homing_busy, servo_on_flag, motion_active_flag} = 4'h0;
	end

	// levels and flags settle before a strobe, so the checker sees the
	// servo, jog, motion and home flags before any request edge reaches it
	task automatic set_state(input logic [3:0] fl, input logic [2:0] cmd,
		input logic [7:0] pos);
		@(posedge aclk);
		{home_done_flag, homing_busy, servo_on_flag, motion_active_flag} <= fl;
		{teach_mode_input, jog_fwd_input, jog_rev_input} <= cmd;
		position_number <= pos;
	endtask

	// one strobe: 0 move, 1 soft reset, 2 position write
	// position number held steady well before and during the edge
	task automatic strobe(input int k);
		repeat (5) @(posedge aclk);
		strobes[2-k] <= 1'b1;
		repeat (6) @(posedge aclk);
		strobes[2-k] <= 1'b0;
		repeat (8) @(posedge aclk);
	endtask
endmodule

/* File: motion_command_alarm_checker_tb_top.sv */
`timescale 1ns/1ps
module motion_command_alarm_checker_tb_top;
	import motion_alarm_pkg::*;
	logic aclk, aresetn, awready, wready, bvalid, bready, arready, rvalid;
	logic awvalid, wvalid, arvalid, rready, alarm_active, irq;
	logic [7:0] awaddr, araddr, position_number;
	logic [31:0] wdata, rdata;
	logic [3:0] wstrb;
	logic [1:0] bresp, rresp;
	logic move_request, soft_reset_request, position_write_strobe;
	logic jog_fwd_input, jog_rev_input, teach_mode_input;
	logic home_done_flag, homing_busy, servo_on_flag, motion_active_flag;
	logic [11:0] alarm_code;
	logic [6:0] ien;
	int miscompares = 0;
	int samples_checked = 0;

	motion_command_alarm_checker i_motion_command_alarm_checker (.*);

	host_pin_model i_host_pin_model (.*);

	// free running 50 MHz clock
	initial
	begin
		aclk = 1'b0;
		forever #10 aclk = ~aclk;
	end

	task automatic complete_run();
		if (miscompares == 0 && samples_checked > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask

	task automatic cmp_word(input string n, input logic [31:0] e,
		input logic [31:0] g);
		samples_checked++;
		if (g !== e)
		begin
			miscompares++;
			$display("BAD %s expected %h seen %h", n, e, g);
		end
	endtask

	task automatic cmp_bit(input string n, input logic e, input logic g);
		samples_checked++;
		if (g !== e)
		begin
			miscompares++;
			$display("BAD %s expected %b seen %b", n, e, g);
		end
	endtask

	// ready is looked at on the falling edge, the value the next rise samples
	task automatic axi_wr(input logic [7:0] a, input logic [31:0] d,
		output logic [1:0] r);
		logic ta, tw;
		@(posedge aclk);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do
		begin
			@(negedge aclk);
			ta = awvalid && awready === 1'b1;
			tw = wvalid && wready === 1'b1;
			@(posedge aclk);
			if (ta) awvalid <= 1'b0;
			if (tw) wvalid <= 1'b0;
		end while (awvalid || wvalid);
		do @(negedge aclk); while (bvalid !== 1'b1);
		r = bresp;
		@(posedge aclk);
		bready <= 1'b0;
	endtask

	task automatic axi_rd(input logic [7:0] a, output logic [31:0] d,
		output logic [1:0] r);
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do @(negedge aclk); while (arready !== 1'b1);
		@(posedge aclk);
		arvalid <= 1'b0;
		do @(negedge aclk); while (rvalid !== 1'b1);
		d = rdata;
		r = rresp;
		@(posedge aclk);
		rready <= 1'b0;
	endtask

	// set mode and pins, strobe once, then check status, latch and irq
	task automatic run_case(input logic [4:0] ctrl, input logic [3:0] fl,
		input logic [2:0] cmd, input logic [7:0] pos, input int k,
		input logic [6:0] st, input logic [11:0] code);
		logic [31:0] d;
		logic [1:0] r;
		axi_wr(OFS_CTRL, 32'(ctrl), r);
		i_host_pin_model.set_state(fl, cmd, pos);
		i_host_pin_model.strobe(k);
		axi_rd(OFS_STAT, d, r);
		cmp_word("status", 32'(st), d);
		axi_rd(OFS_ALARM, d, r);
		cmp_word("alarm", 32'({code != 12'h000, 4'h0, code}), d);
		cmp_word("alarm_code", 32'(code), 32'(alarm_code));
		cmp_bit("alarm_active", code != 12'h000, alarm_active);
		cmp_bit("irq", |(st & ien), irq);
	endtask

	// clears sticky status and resets the latched alarm
	task automatic clear_all();
		logic [1:0] r;
		axi_wr(OFS_ICLR, 32'h0000_007F, r);
		axi_wr(OFS_ALARM, 32'h0000_0000, r);
	endtask

	// main sequence
	initial
	begin
		logic [31:0] d;
		logic [1:0] r;
		logic [7:0] regs [8];
		regs = '{OFS_CTRL, OFS_STAT, OFS_ICLR, OFS_IEN, OFS_ALARM,
			OFS_POSLO, OFS_POSHI, OFS_PINS};
		aresetn = 1'b0;
		{awvalid, wvalid, bready, arvalid, rready} = 5'h00;
		{awaddr, araddr, wdata, wstrb} = 52'h0_0000_0000_000F;
		ien = 7'h00;
		repeat (4) @(posedge aclk);
		aresetn <= 1'b1;
		foreach (regs[i])
		begin
			axi_rd(regs[i], d, r);
			cmp_word("reset value", 32'h0000_0000, d);
			cmp_word("rresp", 32'(RESP_OKAY), 32'(r));
		end
		axi_rd(8'h20, d, r);
		cmp_word("unmapped rresp", 32'(RESP_SLVERR), 32'(r));
		axi_wr(8'h22, 32'h0000_0001, r);
		cmp_word("misaligned bresp", 32'(RESP_SLVERR), 32'(r));
		axi_wr(OFS_STAT, 32'h0000_007F, r);
		ien = 7'h01;
		axi_wr(OFS_IEN, 32'(ien), r);
		cmp_word("bresp", 32'(RESP_OKAY), 32'(r));
		axi_rd(OFS_IEN, d, r);
		cmp_word("enable", 32'(ien), d);
		run_case(5'h00, 4'h0, 3'h0, 8'h00, 0, 7'h01, ALM_HOME_INC);
		run_case(5'h00, 4'h4, 3'h0, 8'h00, 0, 7'h03, ALM_HOME_INC);
		clear_all();
		run_case(5'h03, 4'h4, 3'h0, 8'h00, 0, 7'h02, ALM_HOMING);
		clear_all();
		run_case(5'h04, 4'h0, 3'h0, 8'h00, 0, 7'h01, ALM_HOME_INC);
		clear_all();
		run_case(5'h01, 4'h8, 3'h0, 8'h05, 0, 7'h04, ALM_POS_NUM);
		clear_all();
		axi_wr(OFS_POSLO, 32'h0000_0060, r);
		run_case(5'h00, 4'h8, 3'h0, 8'h05, 0, 7'h00, ALM_NONE);
		run_case(5'h03, 4'h8, 3'h0, 8'h07, 0, 7'h00, ALM_NONE);
		axi_wr(OFS_POSHI, 32'h0000_0100, r);
		axi_rd(OFS_POSHI, d, r);
		cmp_word("valid high", 32'h0000_0100, d);
		run_case(5'h02, 4'h8, 3'h0, 8'h28, 0, 7'h00, ALM_NONE);
		run_case(5'h07, 4'h8, 3'h0, 8'h29, 0, 7'h00, ALM_NONE);
		run_case(5'h02, 4'h8, 3'h0, 8'h41, 0, 7'h04, ALM_POS_NUM);
		clear_all();
		run_case(5'h00, 4'h2, 3'h0, 8'h00, 1, 7'h08, ALM_SRST_SV);
		clear_all();
		run_case(5'h00, 4'h0, 3'h0, 8'h00, 1, 7'h00, ALM_NONE);
		run_case(5'h01, 4'h8, 3'h4, 8'h40, 2, 7'h10, ALM_TEACH_NUM);
		clear_all();
		run_case(5'h01, 4'h8, 3'h4, 8'h3F, 2, 7'h00, ALM_NONE);
		run_case(5'h04, 4'h8, 3'h4, 8'h40, 2, 7'h00, ALM_NONE);
		run_case(5'h12, 4'h8, 3'h6, 8'h01, 2, 7'h20, ALM_JOG_WRT);
		clear_all();
		run_case(5'h12, 4'h9, 3'h4, 8'h01, 2, 7'h20, ALM_JOG_WRT);
		clear_all();
		run_case(5'h02, 4'h8, 3'h5, 8'h01, 2, 7'h00, ALM_NONE);
		run_case(5'h12, 4'h8, 3'h4, 8'h01, 2, 7'h00, ALM_NONE);
		run_case(5'h12, 4'h0, 3'h4, 8'h01, 2, 7'h40, ALM_WRT_HOME);
		clear_all();
		axi_rd(OFS_CTRL, d, r);
		cmp_word("control", 32'h0000_0012, d);
		run_case(5'h00, 4'h0, 3'h4, 8'h01, 2, 7'h00, ALM_NONE);
		complete_run();
	end

	// hang guard, far beyond the fewer than a thousand cycles the cases need
	initial
	begin
		repeat (20000) @(posedge aclk);
		miscompares++;
		complete_run();
	end
endmodule
